// File: include/sync_rx_consts.svh
// Purpose: Constants for the synchronous slave serial receiver
// Assumes: Byte-wide register port, 20 MHz system clock
// Notes: Offsets are word indexes on the plain register port
`ifndef SYNC_RX_CONSTS_SVH
`define SYNC_RX_CONSTS_SVH
`define ADDR_W 3
`define OFS_RX_STATUS 3'h0
`define OFS_RX_BUFFER 3'h1
`define OFS_TX_STATUS 3'h2
`define OFS_BAUD_CTRL 3'h3
`define OFS_BAUD_HIGH 3'h4
`define OFS_BAUD_LOW 3'h5
`define OFS_IRQ_CTRL 3'h6
`define OFS_IRQ_MASK 3'h7
// receive_status_ctrl fields
`define RS_SERIAL_PORT_ENABLE 7
`define RS_RX9 6
`define RS_SINGLE_RECEIVE_ENABLE 5
`define RS_CONTINUOUS_RECEIVE_ENABLE 4
`define RS_FRAMING_ERROR_FLAG 2
`define RS_OVERRUN_ERROR_FLAG 1
`define RS_RECEIVED_NINTH_BIT 0
`define RS_WMASK 8'hf8
// transmit_status_ctrl fields
`define TS_CLOCK_SOURCE_SELECT 7
`define TS_SYNC 4
`define TS_TRMT 1
// irq_control_register fields
`define IC_GIE 7
`define IC_PERIPHERAL_IRQ_ENABLE 6
`define IC_RCIE 5
`define IC_RCIF 0
`define IC_WMASK 8'he0
`define RESET_BYTE 8'h00
`define TRMT_RESET 8'h02
`define BITS_8 4'h8
`define BITS_9 4'h9
`endif

// File: include/sync_rx_pkg.sv
// Purpose: Types for the synchronous slave serial receiver
// Assumes: Nothing beyond the constants header
// Notes: Register bus request travels as one struct
package sync_rx_pkg;
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;
endpackage

// File: verilog/sync_slave_serial_receiver.sv
// Purpose: Receive path of a serial port in synchronous slave mode
// Assumes: Shift clock and data come from an external master, slower
//          than a quarter of clk_i; data sampled on the clock's fall
// Notes: Shift clock and data pass two flops before any logic
`timescale 1ns/1ps
`default_nettype none
`include "sync_rx_consts.svh"

module sync_slave_serial_receiver
    import sync_rx_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic shift_clock_pin_i,
    input wire logic data_pin_i,
    input wire logic low_power_i,
    output logic irq_o,
    output logic wake_o
);
    typedef struct packed {
        logic [1:0] ck_sync;
        logic [1:0] dt_sync;
        logic ck_prev;
        logic [7:0] rx_ctrl;
        logic [7:0] tx_ctrl;
        logic [7:0] baud_ctrl;
        logic [7:0] baud_high;
        logic [7:0] baud_low;
        logic [7:0] irq_ctrl;
        logic [7:0] irq_mask;
        logic [8:0] shift;
        logic [3:0] count;
        logic [7:0] hold;
        logic hold9;
        logic full;
        logic overrun_error_flag;
        logic [7:0] rdata;
    } state_t;

    state_t st_reg, st_next;
    bus_req_t req;
    logic slave_on, ck_fall, rx_en, done, irq_req;
    logic [3:0] word_len;

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    function automatic logic hit(input bus_req_t r, input logic [2:0] a);
        return r.addr == a;
    endfunction

    assign slave_on = st_reg.rx_ctrl[`RS_SERIAL_PORT_ENABLE] & st_reg.tx_ctrl[`TS_SYNC]
        & ~st_reg.tx_ctrl[`TS_CLOCK_SOURCE_SELECT];
    // Single-receive bit stays unread in slave mode
    assign rx_en = slave_on & st_reg.rx_ctrl[`RS_CONTINUOUS_RECEIVE_ENABLE];
    assign ck_fall = st_reg.ck_prev & ~st_reg.ck_sync[1];
    assign word_len = st_reg.rx_ctrl[`RS_RX9] ? `BITS_9 : `BITS_8;
    assign done = rx_en & ck_fall & (st_reg.count == word_len - 4'h1);

    always_comb begin
        st_next = st_reg;
        st_next.ck_sync = {st_reg.ck_sync[0], shift_clock_pin_i};
        st_next.dt_sync = {st_reg.dt_sync[0], data_pin_i};
        st_next.ck_prev = st_reg.ck_sync[1];
        st_next.rdata = `RESET_BYTE;
        // Reads never observe this cycle's writes
        if (req.rd) begin
            unique case (req.addr)
                `OFS_RX_STATUS: st_next.rdata = {st_reg.rx_ctrl[7:3], 1'b0,
                    st_reg.overrun_error_flag, st_reg.hold9};
                `OFS_RX_BUFFER: st_next.rdata = st_reg.hold;
                `OFS_TX_STATUS: st_next.rdata = st_reg.tx_ctrl;
                `OFS_BAUD_CTRL: st_next.rdata = st_reg.baud_ctrl;
                `OFS_BAUD_HIGH: st_next.rdata = st_reg.baud_high;
                `OFS_BAUD_LOW: st_next.rdata = st_reg.baud_low;
                `OFS_IRQ_CTRL: st_next.rdata = {st_reg.irq_ctrl[7:1],
                    st_reg.full};
                `OFS_IRQ_MASK: st_next.rdata = st_reg.irq_mask;
            endcase
            if (hit(req, `OFS_RX_BUFFER)) begin
                st_next.full = 1'b0;
            end
        end
        if (req.wr) begin
            if (hit(req, `OFS_RX_STATUS)) begin
                st_next.rx_ctrl = wdata_i & `RS_WMASK;
            end
            if (hit(req, `OFS_TX_STATUS)) begin
                st_next.tx_ctrl = {wdata_i[7:2], 1'b1, wdata_i[0]};
            end
            if (hit(req, `OFS_BAUD_CTRL)) begin
                st_next.baud_ctrl = wdata_i;
            end
            if (hit(req, `OFS_BAUD_HIGH)) begin
                st_next.baud_high = wdata_i;
            end
            if (hit(req, `OFS_BAUD_LOW)) begin
                st_next.baud_low = wdata_i;
            end
            if (hit(req, `OFS_IRQ_CTRL)) begin
                st_next.irq_ctrl = wdata_i & `IC_WMASK;
            end
            if (hit(req, `OFS_IRQ_MASK)) begin
                st_next.irq_mask = wdata_i;
            end
        end
        if (!rx_en) begin
            // Partial word is dropped when reception stops
            st_next.count = 4'h0;
        end else if (ck_fall) begin
            st_next.shift = {st_reg.dt_sync[1], st_reg.shift[8:1]};
            st_next.count = st_reg.count + 4'h1;
        end
        if (done) begin
            st_next.count = 4'h0;
            if (st_reg.full && !(req.rd && hit(req, `OFS_RX_BUFFER))) begin
                st_next.overrun_error_flag = 1'b1;
            end else begin
                // LSB first; eight-bit words land right-aligned
                if (st_reg.rx_ctrl[`RS_RX9]) begin
                    st_next.hold = st_reg.shift[8:1];
                    st_next.hold9 = st_reg.dt_sync[1];
                end else begin
                    st_next.hold = {st_reg.dt_sync[1], st_reg.shift[8:2]};
                    st_next.hold9 = 1'b0;
                end
                st_next.full = 1'b1;
            end
        end
        if (!st_reg.rx_ctrl[`RS_CONTINUOUS_RECEIVE_ENABLE]) begin
            st_next.overrun_error_flag = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st_reg <= '0;
            st_reg.tx_ctrl <= `TRMT_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign irq_req = st_reg.full & st_reg.irq_ctrl[`IC_RCIE];
    assign wake_o = irq_req & low_power_i;
    assign irq_o = irq_req & st_reg.irq_ctrl[`IC_GIE]
        & st_reg.irq_ctrl[`IC_PERIPHERAL_IRQ_ENABLE];
    assign rdata_o = st_reg.rdata;

    // Receive flag, interrupt gating and wake-up
    a_done_sets_full: assert property (
        @(posedge clk_i) disable iff (reset_i)
        done && !st_reg.full |=> st_reg.full)
        else $error("full not set after word");

    a_gated_irq: assert property (
        @(posedge clk_i) disable iff (reset_i)
        irq_o |-> st_reg.full && st_reg.irq_ctrl[`IC_RCIE])
        else $error("irq without enable");

    a_irq_global_gate: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !st_reg.irq_ctrl[`IC_GIE] |-> !irq_o)
        else $error("irq without global enable");

    a_irq_periph_gate: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !st_reg.irq_ctrl[`IC_PERIPHERAL_IRQ_ENABLE] |-> !irq_o)
        else $error("irq without peripheral enable");

    a_irq_when_enabled: assert property (
        @(posedge clk_i) disable iff (reset_i)
        st_reg.full && st_reg.irq_ctrl[`IC_RCIE] && st_reg.irq_ctrl[`IC_GIE]
        && st_reg.irq_ctrl[`IC_PERIPHERAL_IRQ_ENABLE] |-> irq_o)
        else $error("irq missing with all enables set");

    a_irq_needs_full: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !st_reg.full |-> !irq_o && !wake_o)
        else $error("irq or wake without a word");

    a_wake_gate: assert property (
        @(posedge clk_i) disable iff (reset_i)
        wake_o |-> low_power_i && st_reg.full && st_reg.irq_ctrl[`IC_RCIE])
        else $error("wake without cause");

    a_wake_raised: assert property (
        @(posedge clk_i) disable iff (reset_i)
        low_power_i && st_reg.full && st_reg.irq_ctrl[`IC_RCIE] |-> wake_o)
        else $error("wake missing in low power");

    // Overrun and error clearing
    a_overrun_set: assert property (
        @(posedge clk_i) disable iff (reset_i)
        done && st_reg.full && !req.rd && st_reg.rx_ctrl[`RS_CONTINUOUS_RECEIVE_ENABLE]
        |=> st_reg.overrun_error_flag && $stable(st_reg.hold))
        else $error("overrun not flagged");

    a_continuous_receive_enable_clears_err: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !st_reg.rx_ctrl[`RS_CONTINUOUS_RECEIVE_ENABLE] |=> !st_reg.overrun_error_flag)
        else $error("error kept with receive disabled");

    a_overrun_error_flag_sticky: assert property (
        @(posedge clk_i) disable iff (reset_i)
        st_reg.overrun_error_flag && st_reg.rx_ctrl[`RS_CONTINUOUS_RECEIVE_ENABLE] |=> st_reg.overrun_error_flag)
        else $error("overrun lost while receiving");

    a_overrun_error_flag_cause: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !st_reg.overrun_error_flag && !(done && st_reg.full) |=> !st_reg.overrun_error_flag)
        else $error("overrun without a second word");

    a_overrun_keeps_full: assert property (
        @(posedge clk_i) disable iff (reset_i)
        done && st_reg.full |=> st_reg.full)
        else $error("holding lost on overrun");

    // Enables and mode
    a_no_rx_disabled: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !rx_en |=> st_reg.count == 4'h0)
        else $error("shifting while disabled");

    a_master_blocks: assert property (
        @(posedge clk_i) disable iff (reset_i)
        st_reg.tx_ctrl[`TS_CLOCK_SOURCE_SELECT]
        |=> st_reg.count == 4'h0 && $stable(st_reg.hold))
        else $error("received in master mode");

    a_sync_required: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !st_reg.tx_ctrl[`TS_SYNC] || !st_reg.rx_ctrl[`RS_SERIAL_PORT_ENABLE]
        |=> st_reg.count == 4'h0 && $stable(st_reg.hold))
        else $error("received without slave setup");

    a_single_receive_enable_ignored: assert property (
        @(posedge clk_i) disable iff (reset_i)
        st_reg.rx_ctrl[`RS_SINGLE_RECEIVE_ENABLE] && !st_reg.rx_ctrl[`RS_CONTINUOUS_RECEIVE_ENABLE]
        |=> st_reg.count == 4'h0)
        else $error("single receive started a word");

    // Link sampling
    a_clock_sync: assert property (
        @(posedge clk_i) disable iff (reset_i)
        st_reg.ck_sync[1] == $past(st_reg.ck_sync[0]))
        else $error("clock synchroniser skipped a stage");

    a_data_sync: assert property (
        @(posedge clk_i) disable iff (reset_i)
        st_reg.dt_sync[1] == $past(st_reg.dt_sync[0]))
        else $error("data synchroniser skipped a stage");

    a_fall_edge: assert property (
        @(posedge clk_i) disable iff (reset_i)
        ck_fall |-> $past(st_reg.ck_sync[1]) && !st_reg.ck_sync[1])
        else $error("fall seen without a falling clock");

    a_count_step: assert property (
        @(posedge clk_i) disable iff (reset_i)
        rx_en && ck_fall && !done
        |=> st_reg.count == $past(st_reg.count) + 4'h1)
        else $error("bit not counted on fall");

    a_count_steady: assert property (
        @(posedge clk_i) disable iff (reset_i)
        rx_en && !ck_fall |=> $stable(st_reg.count))
        else $error("bit counted without a fall");

    a_shift_sample: assert property (
        @(posedge clk_i) disable iff (reset_i)
        rx_en && ck_fall |=> st_reg.shift[8] == $past(st_reg.dt_sync[1]))
        else $error("data not sampled on fall");

    a_shift_hold: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !(rx_en && ck_fall) |=> $stable(st_reg.shift))
        else $error("shift register moved without a fall");

    a_word_length: assert property (
        @(posedge clk_i) disable iff (reset_i)
        done |-> st_reg.count == (st_reg.rx_ctrl[`RS_RX9] ? `BITS_9 - 4'h1
            : `BITS_8 - 4'h1))
        else $error("wrong word length");

    a_count_clear_done: assert property (
        @(posedge clk_i) disable iff (reset_i)
        done |=> st_reg.count == 4'h0)
        else $error("count not cleared after word");

    // Word transfer and reads
    a_hold_only_on_done: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !done |=> $stable(st_reg.hold) && $stable(st_reg.hold9))
        else $error("holding changed without a word");

    a_load_eight: assert property (
        @(posedge clk_i) disable iff (reset_i)
        done && !st_reg.full && !st_reg.rx_ctrl[`RS_RX9]
        |=> st_reg.hold[7] == $past(st_reg.dt_sync[1]) && !st_reg.hold9)
        else $error("eight bit word misplaced");

    a_load_nine: assert property (
        @(posedge clk_i) disable iff (reset_i)
        done && !st_reg.full && st_reg.rx_ctrl[`RS_RX9]
        |=> st_reg.hold9 == $past(st_reg.dt_sync[1]))
        else $error("ninth bit misplaced");

    a_full_until_read: assert property (
        @(posedge clk_i) disable iff (reset_i)
        st_reg.full && !(req.rd && req.addr == `OFS_RX_BUFFER)
        |=> st_reg.full)
        else $error("holding released without a read");

    a_read_releases: assert property (
        @(posedge clk_i) disable iff (reset_i)
        req.rd && req.addr == `OFS_RX_BUFFER && !done |=> !st_reg.full)
        else $error("read did not release");

    a_read_and_load: assert property (
        @(posedge clk_i) disable iff (reset_i)
        done && req.rd && req.addr == `OFS_RX_BUFFER |=> st_reg.full)
        else $error("word lost beside a read");

    a_irq_drops_on_read: assert property (
        @(posedge clk_i) disable iff (reset_i)
        req.rd && req.addr == `OFS_RX_BUFFER && !done |=> !irq_o && !wake_o)
        else $error("irq kept after read");

    a_read_data: assert property (
        @(posedge clk_i) disable iff (reset_i)
        req.rd && req.addr == `OFS_RX_BUFFER
        |=> rdata_o == $past(st_reg.hold))
        else $error("holding data mismatch");

    a_status_read: assert property (
        @(posedge clk_i) disable iff (reset_i)
        req.rd && req.addr == `OFS_RX_STATUS
        |=> rdata_o[`RS_OVERRUN_ERROR_FLAG] == $past(st_reg.overrun_error_flag)
        && rdata_o[`RS_RECEIVED_NINTH_BIT] == $past(st_reg.hold9) && !rdata_o[`RS_FRAMING_ERROR_FLAG])
        else $error("status read mismatch");

    a_flag_read: assert property (
        @(posedge clk_i) disable iff (reset_i)
        req.rd && req.addr == `OFS_IRQ_CTRL
        |=> rdata_o[`IC_RCIF] == $past(st_reg.full))
        else $error("done flag read mismatch");

    a_rdata_idle: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !$past(req.rd) |-> rdata_o == `RESET_BYTE)
        else $error("read data outside its cycle");
endmodule // sync_slave_serial_receiver
`default_nettype wire

// File: sim/sync_master_model.sv
// Purpose: External master that clocks words into the receiver
// Assumes: Clock idles high, data sampled by the slave on each fall
// Notes: Clock stands still between frames
`timescale 1ns/1ps
`default_nettype none
module sync_master_model (
    output logic sck_o,
    output logic sda_o
);
    initial begin
        sck_o = 1'b1;
        sda_o = 1'b0;
    end
    task automatic send(input logic [8:0] word, input int nbits);
        // Keep link edges off the system clock edges to avoid races
        #7;
        for (int i = 0; i < nbits; i++) begin
            sda_o = word[i];
            #200 sck_o = 1'b0;
            #200 sck_o = 1'b1;
        end
        // Released line must not keep the last bit
        sda_o = ~sda_o;
    endtask
endmodule // sync_master_model
`default_nettype wire

// File: sim/sync_slave_serial_receiver_tb.sv
// Purpose: Self-checking bench for the slave serial receiver
// Assumes: Fixed 8 cycle wait covers the pin sync delay
// Notes: One task per scenario
`timescale 1ns/1ps
`default_nettype none
`include "sync_rx_consts.svh"
module sync_slave_serial_receiver_tb;
    logic clk_i, reset_i, wr_i, rd_i, low_power_i, irq_o, wake_o, sck, sda;
    logic [2:0] addr_i;
    logic [7:0] wdata_i, rdata_o, v;
    int error_cnt = 0, cmp_count = 0;
    sync_slave_serial_receiver sync_slave_serial_receiver_inst (
        .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .shift_clock_pin_i(sck), .data_pin_i(sda),
        .low_power_i(low_power_i), .irq_o(irq_o), .wake_o(wake_o));
    sync_master_model sync_master_model_inst (.sck_o(sck), .sda_o(sda));
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input int a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a[2:0]; wdata_i <= d; wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input int a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a[2:0]; rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic pause(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic rx(input logic [8:0] w, input int n);
        sync_master_model_inst.send(w, n);
        pause(8);
    endtask
    task automatic s_regs();
        rd(2, v); chk(v, `TRMT_RESET);
        rd(0, v); chk(v, `RESET_BYTE);
        rd(6, v); chk(v, `RESET_BYTE);
        for (int a = 3; a < 8; a++) begin
            if (a != 6) begin
                wr(a[2:0], 8'h5a + a[7:0]);
                rd(a[2:0], v); chk(v, 8'h5a + a[7:0]);
            end
        end
        wr(0, 8'hff); rd(0, v); chk(v, `RS_WMASK);
    endtask
    task automatic s_disabled();
        wr(2, 8'h90); wr(0, 8'h90); rx(9'h0a5, 8);
        rd(6, v); chk(v, 8'h00);
        wr(2, 8'h00); wr(0, 8'h90); rx(9'h0a5, 8);
        rd(6, v); chk(v, 8'h00);
        wr(2, 8'h10); wr(0, 8'h10); rx(9'h0a5, 8);
        rd(6, v); chk(v, 8'h00);
        wr(2, 8'h10); wr(0, 8'h80); rx(9'h0a5, 8);
        rd(6, v); chk(v, 8'h00);
    endtask
    task automatic s_basic();
        wr(6, 8'h00); wr(0, 8'hb0); rx(9'h0a5, 8);
        rd(6, v); chk(v, 8'h01);
        rd(0, v); chk(v, 8'hb0);
        rd(1, v); chk(v, 8'ha5);
        rd(6, v); chk(v, 8'h00);
        wr(0, 8'h90); rx(9'h05a, 8);
        rd(1, v); chk(v, 8'h5a);
    endtask
    task automatic s_irq();
        wr(6, 8'h20); low_power_i <= 1'b1; rx(9'h03c, 8);
        chk({7'h0, irq_o}, 8'h00);
        chk({7'h0, wake_o}, 8'h01);
        wr(6, 8'he0); pause(1);
        chk({7'h0, irq_o}, 8'h01);
        rd(1, v); chk(v, 8'h3c);
        wr(6, 8'hc0); rx(9'h0c3, 8);
        chk({7'h0, irq_o}, 8'h00);
        chk({7'h0, wake_o}, 8'h00);
        rd(1, v); low_power_i <= 1'b0;
    endtask
    task automatic s_nine();
        wr(0, 8'hd0); rx(9'h13c, 9);
        rd(0, v); chk(v, 8'hd1);
        rd(1, v); chk(v, 8'h3c);
    endtask
    task automatic s_overrun();
        wr(0, 8'h90); rx(9'h011, 8); rx(9'h022, 8);
        rd(0, v); chk(v, 8'h92);
        rd(1, v); chk(v, 8'h11);
        wr(0, 8'h80); rd(0, v); chk(v, 8'h80);
    endtask
    task automatic wrap_up();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        reset_i = 1'b1; wr_i = 1'b0; rd_i = 1'b0; low_power_i = 1'b0;
        addr_i = 3'h0; wdata_i = 8'h00;
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        s_regs();
        s_disabled();
        s_basic();
        s_irq();
        s_nine();
        s_overrun();
        wrap_up();
    end
    initial begin
        // Roughly ten times the expected run
        #500000;
        error_cnt++;
        wrap_up();
    end
endmodule // sync_slave_serial_receiver_tb
`default_nettype wire
